// File: shared/cic_defines.vh
// register map, field positions, reset values and timing for the interrupt control block
`ifndef CIC_DEFINES_VH
`define CIC_DEFINES_VH

// byte addresses on the register bus
`define CIC_ADDR_CONTROL      8'h00
`define CIC_ADDR_OPTION       8'h04
`define CIC_ADDR_STATE        8'h08
`define CIC_ADDR_SHADOW_BASE  8'h10

// interrupt_control field positions
`define CIC_BIT_GLB_EN  7
`define CIC_BIT_GRP_EN  6
`define CIC_BIT_T0IE  5
`define CIC_BIT_EPIE  4
`define CIC_BIT_PCIE  3
`define CIC_BIT_T0IF  2
`define CIC_BIT_EPIF  1
`define CIC_BIT_PCSF  0

// option register field position
`define CIC_BIT_EDGE_POL  0

// reset values
`define CIC_CONTROL_RESET   8'h00
`define CIC_EDGE_POL_RESET  1'b1
`define CIC_SHADOW_RESET    8'h00

// shadow slot indexes within the context bus
`define CIC_SH_W       3'h0
`define CIC_SH_STATUS  3'h1
`define CIC_SH_BANK    3'h2
`define CIC_SH_PTR0L   3'h3
`define CIC_SH_PTR0H   3'h4
`define CIC_SH_PTR1L   3'h5
`define CIC_SH_PTR1H   3'h6
`define CIC_SH_PCHI    3'h7
`define CIC_SH_COUNT   8

// status bits that are never saved nor restored (timeout and power-down)
`define CIC_STATUS_KEEP_MASK  8'h18

// program counter width and interrupt vector
`define CIC_PC_W    15
`define CIC_VECTOR  15'h0004

// phase counter value of clock phase one, the first of four phases per instruction cycle
`define CIC_PHASE_ONE  2'h0

`endif

// File: src/cic_edge_detect.v
// synchroniser and selectable edge detector for the external interrupt pin
`timescale 1ns/1ns
`default_nettype none

module cic_edge_detect (
  // clock and reset
  input  wire clk,
  input  wire rst,
  // pin and edge choice
  input  wire pin,
  input  wire rising_sel,
  // one-cycle pulse on the selected edge
  output reg  edge_seen
);

  reg       sync_first;
  reg       sync_second;
  reg       pin_prev;
  reg [1:0] fill;

  // the pin is asynchronous to the core, so two stages before any logic
  always @(posedge clk) begin
    if (rst) begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
      pin_prev    <= 1'b0;
      fill        <= 2'h0;
      edge_seen   <= 1'b0;
    end else begin
      sync_first  <= pin;
      sync_second <= sync_first;
      pin_prev    <= sync_second;
      // no edge until the history holds real pin samples, whatever the pin idles at
      if (fill != 2'h3) begin
        fill <= fill + 2'h1;
      end
      // rising when selected, falling otherwise (see R15)
      if (fill != 2'h3) begin
        edge_seen <= 1'b0;
      end else if (rising_sel) begin
        edge_seen <= sync_second & ~pin_prev;
      end else begin
        edge_seen <= ~sync_second & pin_prev;
      end
    end
  end

endmodule

`default_nettype wire

// File: src/cic_interrupt_control.v
// interrupt control: flags, enables, vector dispatch, wake and shadow context
// Operation
// R01 - any reset leaves interrupts disabled
// R02 - interrupt needs own enable and global enable
// R03 - flags set regardless of any enable
// R04 - entry flushes, clears global, pushes pc, vectors
// R05 - global clear: flag only, serviced later
// R06 - firmware clears serviced flags before return
// R07 - return pops, restores context, sets global
// R08 - synchronous latency three or four cycles
// R09 - asynchronous latency three to five cycles
// R10 - latency independent of instruction length
// R11 - pin flag sampled every phase one
// R12 - firmware enables wake sources before sleep
// R13 - wake vectors only with global enable set
// R14 - one instruction after sleep runs first
// R15 - pin edge selectable rising or falling
// R16 - pin edge sets bit one flag
// R17 - entry saves working, bank, pointers, latch, status
// R18 - return restores shadows, shadow writes take effect
// R19 - shadow copies readable and writable by software
// R20 - control enables read/write, reset to zero
// R21 - timer overflow sets bit two flag
// R22 - pin-change summary read-only, or of flags
// R23 - software clears flags before enabling
// R24 - wake request ignores global enable
`timescale 1ns/1ns
`default_nettype none
`include "cic_defines.vh"

module cic_interrupt_control (
  // clock and reset
  input  wire                     clk,
  input  wire                     rst,
  // register bus
  input  wire                     psel,
  input  wire                     penable,
  input  wire                     pwrite,
  input  wire [7:0]               paddr,
  input  wire [31:0]              pwdata,
  output reg  [31:0]              prdata,
  output wire                     pready,
  output wire                     pslverr,
  // event sources
  input  wire                     timer_zero_overflow,
  input  wire                     edge_pin,
  input  wire [7:0]               port_b_change_flags,
  input  wire                     periph_irq_pending,
  // core pipeline
  input  wire                     instr_done,
  input  wire                     return_from_irq_instruction,
  input  wire                     sleeping,
  input  wire [`CIC_PC_W-1:0]     pc_current,
  input  wire [63:0]              ctx_live,
  // dispatch and context
  output wire                     clock_phase_one,
  output reg                      irq_entry,
  output reg  [`CIC_PC_W-1:0]     push_addr,
  output reg  [`CIC_PC_W-1:0]     vector_addr,
  output reg                      restore_ctx,
  output reg  [63:0]              ctx_restore,
  output wire                     wake_request,
  output wire                     global_irq_enable,
  output wire                     irq_pending
);

  localparam [1:0] S_RUN   = 2'h0;
  localparam [1:0] S_SLEEP = 2'h1;
  localparam [1:0] S_WAKE  = 2'h2;
  localparam [1:0] S_ENTRY = 2'h3;

  // reset image of the control register, picked apart bit by bit
  localparam [7:0] CTL_RESET = `CIC_CONTROL_RESET;

  reg  [1:0] phase;
  reg  [1:0] state;
  reg  [1:0] next_state;

  reg        glb_en;
  reg        grp_en;
  reg        t0ie;
  reg        epie;
  reg        pcie;
  reg        t0if;
  reg        epif;
  reg        edge_pol;

  wire       edge_seen;
  wire       pcsf;
  wire       act_t0;
  wire       act_ep;
  wire       act_pc;
  wire       act_pe;
  wire       any_act;
  wire       take;
  wire [63:0] ctx_save;
  wire [63:0] shadow_flat;

  // bus decode
  wire       acc;
  wire       wr;
  wire       setup;
  wire       hit_ctl;
  wire       hit_opt;
  wire       hit_st;
  wire       hit_sh;
  wire       mapped;
  wire [7:0] sh_off;
  wire [2:0] sh_idx;
  wire [7:0] ctl_value;
  reg  [7:0] rd_value;

  // instruction cycle phase counter, phase one starts each cycle
  always @(posedge clk) begin
    if (rst) begin
      phase <= `CIC_PHASE_ONE;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  assign clock_phase_one = (phase == `CIC_PHASE_ONE);

  // pin edges reach the flag four edges after the pin moves
  cic_edge_detect u_edge (
    .clk        (clk),
    .rst        (rst),
    .pin        (edge_pin),
    .rising_sel (edge_pol),
    .edge_seen  (edge_seen)
  );

  // register bus slave, zero wait states
  // writes to the state word are dropped without an error
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign setup   = psel & ~penable;
  assign sh_off  = paddr - `CIC_ADDR_SHADOW_BASE;
  assign sh_idx  = sh_off[4:2];
  assign hit_ctl = (paddr == `CIC_ADDR_CONTROL);
  assign hit_opt = (paddr == `CIC_ADDR_OPTION);
  assign hit_st  = (paddr == `CIC_ADDR_STATE);
  assign hit_sh  = (sh_off[7:5] == 3'h0) && (sh_off[1:0] == 2'h0);
  assign mapped  = hit_ctl | hit_opt | hit_st | hit_sh;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  assign pcsf = |port_b_change_flags;                       // see R22

  assign ctl_value = {glb_en, grp_en, t0ie, epie, pcie, t0if, epif, pcsf};

  always @* begin
    rd_value = 8'h00;
    if (hit_ctl) begin
      rd_value = ctl_value;
    end else if (hit_opt) begin
      rd_value = {7'h00, edge_pol};
    end else if (hit_st) begin
      rd_value = {3'h0, any_act, state, phase};
    end else if (hit_sh) begin
      rd_value = shadow_flat[sh_idx*8 +: 8];                // see R19
    end
  end

  // read data is captured in the setup cycle and stands through access
  // a read of an unmapped word returns zero
  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (setup & ~pwrite) begin
      prdata <= {24'h0, rd_value};
    end
  end

  // enable qualification
  assign act_t0  = t0if & t0ie;                             // see R02
  assign act_ep  = epif & epie;                             // see R16
  assign act_pc  = pcsf & pcie;
  assign act_pe  = periph_irq_pending & grp_en;             // see R02
  assign any_act = act_t0 | act_ep | act_pc | act_pe;

  // wake does not look at the global enable
  assign wake_request      = any_act;                       // see R24
  assign global_irq_enable = glb_en;
  assign irq_pending       = any_act & glb_en;

  // dispatch only at phase one, whatever instruction is in flight;
  // a wake with the global enable clear just resumes after sleep
  assign take = (state == S_RUN) && clock_phase_one && glb_en && any_act
                && ~sleeping;                               // see R05 see R10 see R11 see R13

  always @* begin
    next_state = state;
    case (state)
      S_RUN: begin
        if (take) begin
          next_state = S_ENTRY;
        end else if (sleeping) begin
          next_state = S_SLEEP;
        end
      end
      S_SLEEP: begin
        if (~sleeping) begin
          next_state = S_WAKE;
        end
      end
      // the instruction after sleep retires before any vectoring
      S_WAKE: begin
        if (instr_done) begin
          next_state = S_RUN;                               // see R14
        end
      end
      // entry is a single cycle; the core flushes and jumps meanwhile
      S_ENTRY: begin
        next_state = S_RUN;
      end
      default: begin
        next_state = S_RUN;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state <= S_RUN;
    end else begin
      state <= next_state;
    end
  end

  // entry strobe: core flushes prefetch, pushes push_addr, jumps to vector
  always @(posedge clk) begin
    if (rst) begin
      irq_entry   <= 1'b0;
      push_addr   <= {`CIC_PC_W{1'b0}};
      vector_addr <= `CIC_VECTOR;
    end else begin
      irq_entry   <= take;                                  // see R04 see R08 see R09
      vector_addr <= `CIC_VECTOR;                           // see R04
      if (take) begin
        push_addr <= pc_current;                            // see R04
      end
    end
  end

  // control enables; entry clears global, return sets it
  always @(posedge clk) begin
    if (rst) begin
      glb_en <= CTL_RESET[`CIC_BIT_GLB_EN];                 // see R01
      grp_en <= CTL_RESET[`CIC_BIT_GRP_EN];                 // see R20
      t0ie   <= CTL_RESET[`CIC_BIT_T0IE];
      epie   <= CTL_RESET[`CIC_BIT_EPIE];
      pcie   <= CTL_RESET[`CIC_BIT_PCIE];
    end else begin
      // entry clear outranks return set, which outranks a write
      if (take) begin
        glb_en <= 1'b0;                                     // see R04
      end else if (return_from_irq_instruction) begin
        glb_en <= 1'b1;                                     // see R07
      end else if (wr && hit_ctl) begin
        glb_en <= pwdata[`CIC_BIT_GLB_EN];
      end
      if (wr && hit_ctl) begin
        grp_en <= pwdata[`CIC_BIT_GRP_EN];                  // see R20
        t0ie <= pwdata[`CIC_BIT_T0IE];
        epie <= pwdata[`CIC_BIT_EPIE];
        pcie <= pwdata[`CIC_BIT_PCIE];
      end
    end
  end

  // flags set by events regardless of enables; a set beats a clear
  always @(posedge clk) begin
    if (rst) begin
      t0if <= CTL_RESET[`CIC_BIT_T0IF];
      epif <= CTL_RESET[`CIC_BIT_EPIF];
    end else begin
      if (timer_zero_overflow) begin
        t0if <= 1'b1;                                       // see R03 see R21
      end else if (wr && hit_ctl) begin
        t0if <= pwdata[`CIC_BIT_T0IF];
      end
      if (edge_seen) begin
        epif <= 1'b1;                                       // see R03 see R16
      end else if (wr && hit_ctl) begin
        epif <= pwdata[`CIC_BIT_EPIF];
      end
    end
  end

  // option register: edge polarity of the external pin
  always @(posedge clk) begin
    if (rst) begin
      edge_pol <= `CIC_EDGE_POL_RESET;
    end else if (wr && hit_opt) begin
      edge_pol <= pwdata[`CIC_BIT_EDGE_POL];                // see R15
    end
  end

  // timeout and power-down status bits are not saved
  assign ctx_save = ctx_live & ~({56'h0, `CIC_STATUS_KEEP_MASK}
                    << (`CIC_SH_STATUS * 8));               // see R17

  // shadow bank: loaded on entry, otherwise software may rewrite it
  genvar gi;
  generate
    for (gi = 0; gi < `CIC_SH_COUNT; gi = gi + 1) begin : g_shadow
      // an entry load outranks a software write in the same cycle
      localparam [31:0] IDX = gi;
      reg [7:0] slot;
      always @(posedge clk) begin
        if (rst) begin
          slot <= `CIC_SHADOW_RESET;
        end else if (take) begin
          slot <= ctx_save[gi*8 +: 8];                      // see R17
        end else if (wr && hit_sh && ({29'h0, sh_idx} == IDX)) begin
          slot <= pwdata[7:0];                              // see R19
        end
      end
      assign shadow_flat[gi*8 +: 8] = slot;
    end
  endgenerate

  // return: shadow contents overwrite the live context
  // timeout and power-down keep their live values
  always @(posedge clk) begin
    if (rst) begin
      restore_ctx <= 1'b0;
      ctx_restore <= 64'h0;
    end else begin
      restore_ctx <= return_from_irq_instruction;           // see R07
      if (return_from_irq_instruction) begin
        ctx_restore <= (shadow_flat & ~({56'h0, `CIC_STATUS_KEEP_MASK}
                        << (`CIC_SH_STATUS * 8)))
                       | (ctx_live & ({56'h0, `CIC_STATUS_KEEP_MASK}
                        << (`CIC_SH_STATUS * 8)));          // see R18
      end
    end
  end

endmodule

`default_nettype wire

// File: testbench/cic_core_model.sv
// core pipeline model: retires instructions and follows vector jumps
`timescale 1ns/1ns
`default_nettype none
module cic_core_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // pace and dispatch
  input  wire logic        slow,
  input  wire logic        irq_entry,
  input  wire logic [14:0] vector_addr,
  // retire stream
  output var  logic        instr_done,
  output var  logic [14:0] pc_current,
  output var  logic [63:0] ctx_live
);
  logic       last;
  logic [2:0] cnt;
  assign last = (cnt == (slow ? 3'h7 : 3'h3));
  always @(posedge clk) begin
    if (rst) begin
      cnt        <= 3'h0;
      instr_done <= 1'b0;
      pc_current <= 15'h0000;
      ctx_live   <= 64'h0f1e2d3c4b5a6978;
    end else begin
      cnt        <= last ? 3'h0 : cnt + 3'h1;
      instr_done <= last;
      if (irq_entry)
        pc_current <= vector_addr;
      else if (instr_done) begin
        pc_current <= pc_current + 15'h0001;
        ctx_live   <= {ctx_live[55:0], ctx_live[63:56] + 8'h11};
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/cic_props.sv
// assertions on the interrupt control block ports
`timescale 1ns/1ns
`default_nettype none
module cic_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // core side
  input wire logic        sleeping,
  input wire logic        return_from_irq_instruction,
  input wire logic [14:0] pc_current,
  // dispatch
  input wire logic        clock_phase_one,
  input wire logic        irq_entry,
  input wire logic [14:0] push_addr,
  input wire logic [14:0] vector_addr,
  input wire logic        restore_ctx,
  input wire logic        wake_request,
  input wire logic        global_irq_enable,
  input wire logic        irq_pending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_off3;
    !clock_phase_one [*3];
  endsequence
  a_phase_period: assert property (clock_phase_one |=> s_off3 ##1 clock_phase_one)
    else $error("phase one gap wrong");
  a_entry_cause: assert property (irq_entry |-> $past(irq_pending && clock_phase_one))
    else $error("entry without pending at phase one");
  a_entry_vector: assert property (irq_entry |-> vector_addr == 15'h0004 && !global_irq_enable)
    else $error("entry vector or global enable wrong");
  a_entry_push: assert property (irq_entry |-> push_addr == $past(pc_current))
    else $error("pushed address wrong");
  a_entry_spacing: assert property (irq_entry |=> !irq_entry [*3])
    else $error("entries too close");
  a_return_gie: assert property (return_from_irq_instruction |=> restore_ctx && global_irq_enable)
    else $error("return did not restore");
  a_pending_def: assert property (irq_pending == (wake_request && global_irq_enable))
    else $error("pending not wake and global");
  a_sleep_hold: assert property (sleeping |=> !irq_entry)
    else $error("entry while asleep");
  a_reset_off: assert property ($past(rst) |-> !global_irq_enable)
    else $error("global enable after reset");
endmodule
bind cic_interrupt_control cic_props i_cic_props (.clk(clk), .rst(rst), .sleeping(sleeping),
  .return_from_irq_instruction(return_from_irq_instruction), .pc_current(pc_current),
  .clock_phase_one(clock_phase_one), .irq_entry(irq_entry), .push_addr(push_addr),
  .vector_addr(vector_addr), .restore_ctx(restore_ctx), .wake_request(wake_request),
  .global_irq_enable(global_irq_enable), .irq_pending(irq_pending));
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the interrupt control block
`timescale 1ns/1ns
`default_nettype none
`include "cic_defines.vh"
module testbench;
  localparam logic [7:0] ctl_a = `CIC_ADDR_CONTROL;
  localparam logic [7:0] opt_a = `CIC_ADDR_OPTION;
  localparam logic [7:0] sh_a  = `CIC_ADDR_SHADOW_BASE;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        t0 = 1'b0, pin = 1'b0, pp = 1'b0, ret = 1'b0, slp = 1'b0, slow = 1'b0;
  logic [7:0]  paddr = 8'h00, pbf = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, ido, ent, rctx, ph1, wake, glb, pend;
  logic [14:0] pc, push, vec;
  logic [63:0] ctx, crs, ctx_q, cap;
  int          miscompares = 0, n_compared = 0, n_ent = 0, n_ido = 0, n, k, lat;
  cic_interrupt_control i_cic_interrupt_control (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_zero_overflow(t0), .edge_pin(pin),
    .port_b_change_flags(pbf), .periph_irq_pending(pp), .instr_done(ido),
    .return_from_irq_instruction(ret), .sleeping(slp), .pc_current(pc), .ctx_live(ctx),
    .clock_phase_one(ph1), .irq_entry(ent), .push_addr(push), .vector_addr(vec),
    .restore_ctx(rctx), .ctx_restore(crs), .wake_request(wake), .global_irq_enable(glb),
    .irq_pending(pend));
  cic_core_model i_cic_core_model (.clk(clk), .rst(rst), .slow(slow), .irq_entry(ent),
    .vector_addr(vec), .instr_done(ido), .pc_current(pc), .ctx_live(ctx));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic pulse_t0();
    @(posedge clk);
    t0 <= 1'b1;
    @(posedge clk);
    t0 <= 1'b0;
  endtask
  task automatic wait_ent(input int lim);
    n = 0;
    while (ent !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    ctx_q <= ctx;
    if (ent === 1'b1) n_ent <= n_ent + 1;
    if (ido === 1'b1) n_ido <= n_ido + 1;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc(ctl_a, 32'h00);
    rdc(opt_a, 32'h01);
    apb(1'b1, 8'h40, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, `CIC_ADDR_STATE, 32'hff);
    chk(err, 1'b0);
    apb(1'b1, ctl_a, 32'h7f);
    rdc(ctl_a, 32'h7e);
    chk(wake, 1'b1);
    chk(pend, 1'b0);
    apb(1'b1, ctl_a, 32'h00);
    pulse_t0();
    rdc(ctl_a, 32'h04);
    chk(n_ent, 0);
    apb(1'b1, ctl_a, 32'ha4);
    wait_ent(16);
    chk(ent, 1'b1);
    cap = ctx_q;
    apb(1'b1, ctl_a, 32'h20);
    rdc(sh_a, {24'h0, cap[7:0]});
    rdc(sh_a + 8'h04, {24'h0, cap[15:8] & 8'he7});
    apb(1'b1, sh_a, 32'h5a);
    rdc(sh_a, 32'h5a);
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    @(posedge clk);
    chk(rctx, 1'b1);
    chk(crs[7:0], 8'h5a);
    chk(glb, 1'b1);
    chk(crs[15:8], (cap[15:8] & 8'he7) | (ctx_q[15:8] & 8'h18));
    k = n_ent;
    repeat (16) @(posedge clk);
    chk(n_ent, k);
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      apb(1'b1, ctl_a, 32'ha0);
      while (ph1 !== 1'b1) @(posedge clk);
      pulse_t0();
      wait_ent(16);
      if (s == 0) lat = n;
      chk(n, lat);
      chk(n <= 6, 1'b1);
      apb(1'b1, ctl_a, 32'h00);
    end
    for (int p = 1; p >= 0; p--) begin
      apb(1'b1, opt_a, p);
      pin <= ~p[0];
      repeat (8) @(posedge clk);
      apb(1'b1, ctl_a, 32'h00);
      pin <= p[0];
      repeat (8) @(posedge clk);
      rdc(ctl_a, 32'h02);
    end
    pbf <= 8'h10;
    apb(1'b1, ctl_a, 32'h00);
    rdc(ctl_a, 32'h01);
    pbf <= 8'h00;
    pp  <= 1'b1;
    rdc(ctl_a, 32'h00);
    chk(wake, 1'b0);
    apb(1'b1, ctl_a, 32'h40);
    rdc(ctl_a, 32'h40);
    chk(wake, 1'b1);
    pp  <= 1'b0;
    apb(1'b1, ctl_a, 32'ha0);
    slp <= 1'b1;
    k = n_ent;
    pulse_t0();
    repeat (8) @(posedge clk);
    chk(wake, 1'b1);
    chk(n_ent, k);
    k = n_ido;
    slp <= 1'b0;
    wait_ent(16);
    chk(ent, 1'b1);
    chk(n_ido > k, 1'b1);
    apb(1'b1, ctl_a, 32'h80);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(ctl_a, 32'h00);
    finish_test();
  end
endmodule
`default_nettype wire
